// ==== ibfc_map.svh ====
// Register addresses, bit positions and reset values of the bus flag block
`ifndef IBFC_MAP_SVH
`define IBFC_MAP_SVH
`define IBFC_ADDR_W          16
`define IBFC_FLAG_ADDR       16'hFFAB
`define IBFC_CLKSEL_ADDR     16'hFFA8
`define IBFC_FLAG_RESET      8'h00
`define IBFC_CLKSEL_RESET    8'h00
`define IBFC_FLAG_STF_BIT    7
`define IBFC_FLAG_BSY_BIT    6
`define IBFC_FLAG_ISE_BIT    1
`define IBFC_FLAG_RSV_BIT    0
`define IBFC_CLKSEL_CLD_BIT  5
`define IBFC_CLKSEL_DAD_BIT  4
`define IBFC_CLKSEL_WMASK    4'hF
`define IBFC_CLKSEL_SEL_MSB  3
`define IBFC_RDATA_IDLE      8'h00
`define IBFC_SYNC_RESET      3'h7
`endif

// ==== ibfc_pkg.sv ====
// Types shared by the bus flag block
package ibfc_pkg;
    // Bus events seen on the line
    typedef struct packed {
        logic start_det;
        logic stop_det;
    } ibfc_bus_evt_t;

    // Register read and write strobe bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ibfc_cpu_req_t;
endpackage

// ==== ibfc_pin_sync.sv ====
// Three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/10ps
`include "ibfc_map.svh"
module ibfc_pin_sync
    import ibfc_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    // State: three sync stages plus accepted level
    typedef struct packed {
        logic [2:0] sync;
        logic       level;
    } ibfc_sync_state_t;

    ibfc_sync_state_t st_r;
    ibfc_sync_state_t st_nxt;

    // Stage 0 is only read by stage 1
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.sync  = {st_r.sync[1:0], pin_in};
        if (st_r.sync[1] == st_r.sync[2])
        begin
            st_nxt.level = st_r.sync[2];
        end
    end

    // Idle bus is high, so reset to high
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= {`IBFC_SYNC_RESET, 1'b1};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.level;
endmodule

// ==== ibfc_top.sv ====
// Flag and clock-selection registers of the bus interface, with busy tracking
//==============================================================================
//==============================================================================
`timescale 1ns/10ps
`include "ibfc_map.svh"
module ibfc_top
    import ibfc_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        cpu_wr_in,
    input  wire logic        cpu_rd_in,
    input  wire logic [15:0] cpu_addr_in,
    input  wire logic [7:0]  cpu_wdata_in,
    input  wire logic        interface_operation_enable_in,
    input  wire logic        start_trigger_in,
    input  wire logic        start_fail_in,
    input  wire logic        start_det_in,
    input  wire logic        stop_det_in,
    input  wire logic        scl_pin_in,
    input  wire logic        sda_pin_in,
    output logic [7:0]       cpu_rdata_out,
    output logic             start_permit_out,
    output logic             reservation_disable_out,
    output logic [3:0]       clock_select_out
);
    //==========================================================================
    // State
    // Delayed copies of enable and trigger give the edges that set and clear the flags
    typedef struct packed {
        logic       start_fail_flag;
        logic       bus_busy_flag;
        logic       initial_start_enable;
        logic       reservation_disable;
        logic       stop_seen;
        logic       enable_d;
        logic       trig_d;
        logic [3:0] clk_sel;
        logic       clock_line_level;
        logic       data_line_level;
        logic [7:0] rdata;
        logic       start_permit;
    } ibfc_state_t;

    ibfc_state_t   st_r;
    ibfc_state_t   st_nxt;
    ibfc_cpu_req_t req;
    logic          scl_lvl;
    logic          sda_lvl;

    // Bundle the strobes so the decode below reads as one request
    assign req = '{wr: cpu_wr_in, rd: cpu_rd_in, addr: cpu_addr_in, wdata: cpu_wdata_in};

    // Address decode shared by read and write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    // Flag register image; bits five down to two are tied to zero
    function automatic logic [7:0] flag_image(input ibfc_state_t s);
        logic [7:0] img;
        img                     = `IBFC_RDATA_IDLE;
        img[`IBFC_FLAG_STF_BIT] = s.start_fail_flag;
        img[`IBFC_FLAG_BSY_BIT] = s.bus_busy_flag;
        img[`IBFC_FLAG_ISE_BIT] = s.initial_start_enable;
        img[`IBFC_FLAG_RSV_BIT] = s.reservation_disable;
        return img;
    endfunction

    // Clock selection image; the two top bits are tied to zero
    function automatic logic [7:0] clksel_image(input ibfc_state_t s);
        logic [7:0] img;
        img                              = `IBFC_RDATA_IDLE;
        img[`IBFC_CLKSEL_SEL_MSB:0]      = s.clk_sel;
        img[`IBFC_CLKSEL_CLD_BIT]        = s.clock_line_level;
        img[`IBFC_CLKSEL_DAD_BIT]        = s.data_line_level;
        return img;
    endfunction

    //==========================================================================
    // Pin level synchronisers, one per bus line; index 1 is the clock line
    // Lines move with no regard to our clock, so each passes three flops
    // and a change counts only once the last two stages agree
    logic [1:0] line_pins;
    logic [1:0] line_lvls;

    assign line_pins = {scl_pin_in, sda_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < $bits(line_pins); gi = gi + 1)
        begin : g_line_sync
            ibfc_pin_sync u_sync
            (
                .ref_clk_in (ref_clk_in),
                .rst_in     (rst_in),
                .pin_in     (line_pins[gi]),
                .level_out  (line_lvls[gi])
            );
        end
    endgenerate

    // Accepted levels of the clock and data lines
    assign scl_lvl = line_lvls[1];
    assign sda_lvl = line_lvls[0];

    //==========================================================================
    // Next-state logic
    always_comb
    begin
        // Defaults hold every field; the delayed copies follow their inputs
        st_nxt          = st_r;
        st_nxt.enable_d = interface_operation_enable_in;
        st_nxt.trig_d   = start_trigger_in;

        // Writes while enabled are dropped; protects live config
        if (req.wr && hit(req.addr, `IBFC_FLAG_ADDR) && !interface_operation_enable_in)
        begin
            st_nxt.reservation_disable  = req.wdata[`IBFC_FLAG_RSV_BIT];
            st_nxt.initial_start_enable = req.wdata[`IBFC_FLAG_ISE_BIT];
        end
        if (req.wr && hit(req.addr, `IBFC_CLKSEL_ADDR) && !interface_operation_enable_in)
        begin
            // Only the select field lands; line level bits are never written
            st_nxt.clk_sel = req.wdata[`IBFC_CLKSEL_SEL_MSB:0] & `IBFC_CLKSEL_WMASK;
        end

        // Start-fail: set wins over clear in one cycle; a failed start needs the block enabled
        // Trigger written one and trigger cleared are taken from the trigger's edges
        if (start_fail_in && !start_trigger_in && st_r.trig_d && st_r.reservation_disable &&
            interface_operation_enable_in)
        begin
            st_nxt.start_fail_flag = 1'b1;
        end
        else if ((start_trigger_in && !st_r.trig_d) || !interface_operation_enable_in)
        begin
            st_nxt.start_fail_flag = 1'b0;
        end

        // Busy tracking; a start detected wins over stop in the same cycle
        // The enable edge comes from the registered enable, so a held enable
        // cannot set busy again after a stop has cleared it
        // With initial-start set the busy bit ignores the real bus until a start
        if (!interface_operation_enable_in)
        begin
            st_nxt.bus_busy_flag = 1'b0;
            st_nxt.stop_seen     = 1'b0;
        end
        else if (start_det_in)
        begin
            st_nxt.bus_busy_flag = 1'b1;
        end
        else if (stop_det_in)
        begin
            st_nxt.bus_busy_flag = 1'b0;
            st_nxt.stop_seen     = 1'b1;
        end
        else if (!st_r.enable_d && !st_r.initial_start_enable)
        begin
            st_nxt.bus_busy_flag = 1'b1;
        end

        // Stop clears initial-start whether or not the block is enabled
        if (stop_det_in)
        begin
            st_nxt.initial_start_enable = 1'b0;
        end

        // Start allowed once a stop is seen, or at once with initial-start
        st_nxt.start_permit = interface_operation_enable_in &&
                              (st_nxt.stop_seen || st_nxt.initial_start_enable);

        // Line levels only valid while enabled
        st_nxt.clock_line_level = interface_operation_enable_in && scl_lvl;
        st_nxt.data_line_level  = interface_operation_enable_in && sda_lvl;

        // Registered read data; unmapped addresses read zero
        // Zero between reads, so a stale byte never looks like a fresh answer
        st_nxt.rdata = `IBFC_RDATA_IDLE;
        if (req.rd && hit(req.addr, `IBFC_FLAG_ADDR))
        begin
            st_nxt.rdata = flag_image(st_r);
        end
        else if (req.rd && hit(req.addr, `IBFC_CLKSEL_ADDR))
        begin
            st_nxt.rdata = clksel_image(st_r);
        end
    end

    //==========================================================================
    // State register
    // Asynchronous reset returns every field, read data included, to zero
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register, with no logic after it
    assign cpu_rdata_out           = st_r.rdata;
    assign start_permit_out        = st_r.start_permit;
    assign reservation_disable_out = st_r.reservation_disable;
    assign clock_select_out        = st_r.clk_sel;
endmodule

// ==== ibfc_checker.sv ====
// Port assertions and covers of the bus flag block
`timescale 1ns/10ps
module ibfc_checker
    import ibfc_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        cpu_wr_in,
    input wire logic        cpu_rd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic        interface_operation_enable_in,
    input wire logic [7:0]  cpu_rdata_out,
    input wire logic        start_permit_out,
    input wire logic        reservation_disable_out,
    input wire logic [3:0]  clock_select_out
);
    //==========
    // Decoded accesses
    wire logic fl_rd = cpu_rd_in && cpu_addr_in == 16'hFFAB;
    wire logic cs_rd = cpu_rd_in && cpu_addr_in == 16'hFFA8;
    wire logic en    = interface_operation_enable_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    //==========
    // Read data shape, register holds and disable effects
    chk_flag_gaps: assert property ($past(fl_rd) |-> cpu_rdata_out[5:2] == 4'h0)
        else $error("flag gap bits set");
    chk_clksel_top: assert property ($past(cs_rd) |-> cpu_rdata_out[7:6] == 2'h0)
        else $error("clksel top bits set");
    chk_levels_off: assert property ($past(cs_rd && !en) && $past(!en, 2) |-> cpu_rdata_out[5:4] == 2'h0)
        else $error("line levels shown while off");
    chk_rsv_echo: assert property ($past(fl_rd) |-> cpu_rdata_out[0] == $past(reservation_disable_out))
        else $error("reservation bit mismatch");
    chk_rsv_hold: assert property (!$past(cpu_wr_in && cpu_addr_in == 16'hFFAB && !en)
        |-> $stable(reservation_disable_out)) else $error("reservation bit moved");
    chk_cs_hold: assert property (!$past(cpu_wr_in && cpu_addr_in == 16'hFFA8 && !en)
        |-> $stable(clock_select_out)) else $error("clock select moved");
    chk_permit_off: assert property ($past(!en) |-> !start_permit_out)
        else $error("start permitted while off");
    chk_busy_off: assert property ($past(fl_rd && !en) && $past(!en, 2) && $past(!en, 3)
        |-> !cpu_rdata_out[6]) else $error("busy while off");
    // Main scenarios reached
    cov_flag_read: cover property (fl_rd && en);
    cov_permit: cover property ($rose(start_permit_out));
    cov_cs_write: cover property (cpu_wr_in && cpu_addr_in == 16'hFFA8 && !en);
endmodule
bind ibfc_top ibfc_checker ibfc_checker_inst (.ref_clk_in, .rst_in, .cpu_wr_in, .cpu_rd_in, .cpu_addr_in,
    .interface_operation_enable_in, .cpu_rdata_out, .start_permit_out, .reservation_disable_out,
    .clock_select_out);

// ==== ibfc_bus_model.sv ====
// Other masters and slaves sharing the two-wire bus
`timescale 1ns/10ps
module ibfc_bus_model
    import ibfc_pkg::*;
(
    input  wire logic    ref_clk_in,
    output ibfc_bus_evt_t evt_out,
    output logic         scl_out,
    output logic         sda_out
);
    // Lines idle high through the pull-ups
    initial
    begin
        evt_out = '0;
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Third-party condition; detector pulse lasts one cycle
    task automatic cond(input logic is_start);
        @(posedge ref_clk_in);
        evt_out <= is_start ? 2'b10 : 2'b01;
        sda_out <= !is_start;
        @(posedge ref_clk_in);
        evt_out <= '0;
    endtask
    // Raw levels for the level detection bits
    task automatic lines(input logic s, input logic d);
        @(posedge ref_clk_in);
        scl_out <= s;
        sda_out <= d;
    endtask
endmodule

// ==== i2c_bus_flag_control_bench.sv ====
// Self-checking bench of the bus flag block
`timescale 1ns/10ps
module i2c_bus_flag_control_bench;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wdata   = 8'h00;
    logic        ena     = 1'b0;
    logic        trig    = 1'b0;
    logic        fail    = 1'b0;
    logic [7:0]  rdata;
    logic [3:0]  csel;
    logic        permit;
    logic        rsv;
    logic        scl;
    logic        sda;
    logic [7:0]  v;
    int          errors  = 0;
    int          checks  = 0;
    int          seed    = 49;
    ibfc_pkg::ibfc_bus_evt_t evt;
    always #50 ref_clk = ~ref_clk;
    ibfc_top ibfc_top_inst (.ref_clk_in(ref_clk), .rst_in(rst), .cpu_wr_in(wr), .cpu_rd_in(rd),
        .cpu_addr_in(addr), .cpu_wdata_in(wdata), .interface_operation_enable_in(ena),
        .start_trigger_in(trig), .start_fail_in(fail), .start_det_in(evt.start_det),
        .stop_det_in(evt.stop_det), .scl_pin_in(scl), .sda_pin_in(sda), .cpu_rdata_out(rdata),
        .start_permit_out(permit), .reservation_disable_out(rsv), .clock_select_out(csel));
    ibfc_bus_model ibfc_bus_model_inst (.ref_clk_in(ref_clk), .evt_out(evt), .scl_out(scl), .sda_out(sda));
    //==========
    // Helpers: flag image, compare, bus cycles
    function automatic logic [7:0] fl(input logic [3:0] b);
        return {b[3:2], 4'h0, b[1:0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    task automatic get(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 cmp(rdata, e);
    endtask
    // Trigger written one, then cleared
    task automatic tp;
        @(posedge ref_clk);
        trig <= 1'b1;
        @(posedge ref_clk);
        trig <= 1'b0;
        at(2);
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    //==========
    // Main sequence
    initial
    begin
        at(5);
        rst <= 1'b0;
        get(16'hFFAB, 8'h00);
        get(16'hFFA8, 8'h00);
        get(16'h0000, 8'h00);
        repeat (16)
        begin
            v = $random(seed);
            put(16'hFFAB, v);
            get(16'hFFAB, fl({2'b00, v[1:0]}));
            put(16'hFFA8, v);
            get(16'hFFA8, {4'h0, v[3:0]});
            cmp(8'(csel), 8'(v[3:0]));
        end
        put(16'hFFAB, 8'hFD);
        #1 cmp(8'(rsv), 8'h01);
        @(posedge ref_clk);
        ena <= 1'b1;
        put(16'hFFAB, 8'h02);
        put(16'hFFA8, ~v);
        get(16'hFFAB, fl(4'b0101));
        get(16'hFFA8, {4'h3, v[3:0]});
        cmp(8'(csel), 8'(v[3:0]));
        cmp(8'(permit), 8'h00);
        ibfc_bus_model_inst.cond(1'b0);
        get(16'hFFAB, fl(4'b0001));
        cmp(8'(permit), 8'h01);
        @(posedge ref_clk);
        fail <= 1'b1;
        tp();
        get(16'hFFAB, fl(4'b1001));
        @(posedge ref_clk);
        trig <= 1'b1;
        get(16'hFFAB, fl(4'b0001));
        @(posedge ref_clk);
        trig <= 1'b0;
        ibfc_bus_model_inst.cond(1'b1);
        get(16'hFFAB, fl(4'b1101));
        @(posedge ref_clk);
        ena  <= 1'b0;
        fail <= 1'b0;
        at(3);
        get(16'hFFAB, fl(4'b0001));
        put(16'hFFAB, 8'h02);
        ibfc_bus_model_inst.lines(1'b1, 1'b0);
        @(posedge ref_clk);
        ena <= 1'b1;
        at(6);
        get(16'hFFAB, fl(4'b0010));
        cmp(8'(permit), 8'h01);
        get(16'hFFA8, {4'h2, v[3:0]});
        @(posedge ref_clk);
        fail <= 1'b1;
        tp();
        get(16'hFFAB, fl(4'b0010));
        ibfc_bus_model_inst.cond(1'b0);
        get(16'hFFAB, fl(4'b0000));
        ibfc_bus_model_inst.cond(1'b1);
        get(16'hFFAB, fl(4'b0100));
        // Mid-run reset with busy set: both registers must come back as zero
        @(posedge ref_clk);
        rst <= 1'b1;
        ena <= 1'b0;
        at(2);
        rst <= 1'b0;
        get(16'hFFAB, 8'h00);
        get(16'hFFA8, 8'h00);
        cmp(8'(csel), 8'h00);
        conclude();
    end
    // Watchdog, well past the expected run of a few hundred cycles
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule
